// File: core/pci_ctrl.sv
// Pin-change interrupt controller and configuration registers of an 8-bit expander.
// Assumes the serial engine presents one-cycle register strobes on sys_clk and
// supplies the pin direction; pin levels arrive asynchronously.
//
// What this block does
// - Enable bit 1 lets its pin interrupt
// - Default mode: pin opposite default bit interrupts
// - Mode bit 1 selects default compare
// - Mode bit 0 compares against previous value
// - Config bit 5 stops address auto-increment
// - Config bit 4 disables data slew control
// - Config bit 3 enables address pins (SPI)
// - Config bit 2 selects open-drain, overrides polarity
// - Config bit 1 sets push-pull active level
// - Config bits 7, 6, 0 read zero
// - Pull-up only when bit set and input
// - Flag bits show pending pin interrupts
// - Flag register ignores writes
// - Later pins flag without recapturing port
// - Output pins never cause interrupts
// - First event captures port, then holds
// - Read of capture or port clears
// - Previous-value reference updates on interrupt
`timescale 1ns/1ns
module pci_ctrl #(
    parameter bit SPI_VARIANT = 1'b1
) (
    // Clock, reset, enable
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic ce,
    // Register port from the serial engine
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // Port side
    input wire logic [7:0] pin_level,
    input wire logic [7:0] pin_is_input,
    output logic [7:0] pullup_enable,
    output logic [7:0] irq_capture,
    // Configuration to the serial engine and pads
    output logic addr_autoinc_disable,
    output logic data_slew_disable,
    output logic hw_address_enable,
    // Interrupt pin
    output logic irq_pin_o,
    output logic irq_pin_oe
);

    logic [7:0] pin_change_irq_enable;
    logic [7:0] compare_default_value;
    logic [7:0] compare_mode_select;
    logic [7:0] expander_configuration;
    logic [7:0] pullup_enable_reg;
    logic [7:0] port_sync;
    logic [7:0] next_rdata;
    logic pending;
    logic any_cond;
    logic read_clear;
    logic open_drain;
    logic active_high;

    pci_pin_if pif ();

    pci_sync #(
        .W(pci_pkg::PORT_W)
    ) u_sync (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .ce(ce),
        .async_in(pin_level),
        .sync_out(port_sync)
    );

    for (genvar g = 0; g < pci_pkg::PORT_W; g++) begin : g_pin
        pci_pin_detect #(
            .IDX(g)
        ) u_pin (
            .sys_clk(sys_clk),
            .reset_n(reset_n),
            .p(pif.pin)
        );
    end

    assign pif.ce = ce;
    assign pif.clear = read_clear;
    assign pif.enable = pin_change_irq_enable;
    assign pif.is_input = pin_is_input;
    assign pif.mode = compare_mode_select;
    assign pif.default_val = compare_default_value;
    assign pif.level = port_sync;

    assign any_cond = |pif.cond;
    // Only reads clear; writes to these addresses leave the interrupt alone
    assign read_clear = ce && reg_rd && (reg_addr == pci_pkg::ADDR_IRQ_CAPTURE
                                      || reg_addr == pci_pkg::ADDR_PORT_VALUE);
    assign open_drain = expander_configuration[pci_pkg::CFG_OPEN_DRAIN_BIT];
    assign active_high = expander_configuration[pci_pkg::CFG_ACTIVE_HIGH_BIT];

    // Writable registers; the flag register has no write path at all
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            pin_change_irq_enable <= pci_pkg::RST_IRQ_ENABLE;
            compare_default_value <= pci_pkg::RST_CMP_DEFAULT;
            compare_mode_select <= pci_pkg::RST_CMP_MODE;
            expander_configuration <= pci_pkg::RST_CONFIG;
            pullup_enable_reg <= pci_pkg::RST_PULLUP;
        end else if (ce && reg_wr) begin
            case (reg_addr)
                pci_pkg::ADDR_IRQ_ENABLE: pin_change_irq_enable <= reg_wdata;
                pci_pkg::ADDR_CMP_DEFAULT: compare_default_value <= reg_wdata;
                pci_pkg::ADDR_CMP_MODE: compare_mode_select <= reg_wdata;
                pci_pkg::ADDR_CONFIG: begin
                    expander_configuration <= reg_wdata & pci_pkg::CFG_WRITABLE_MASK;
                end
                pci_pkg::ADDR_PULLUP: pullup_enable_reg <= reg_wdata;
                default: begin
                end
            endcase
        end
    end

    always_comb begin
        case (reg_addr)
            pci_pkg::ADDR_IRQ_ENABLE: next_rdata = pin_change_irq_enable;
            pci_pkg::ADDR_CMP_DEFAULT: next_rdata = compare_default_value;
            pci_pkg::ADDR_CMP_MODE: next_rdata = compare_mode_select;
            pci_pkg::ADDR_CONFIG: next_rdata = expander_configuration;
            pci_pkg::ADDR_PULLUP: next_rdata = pullup_enable_reg;
            pci_pkg::ADDR_IRQ_FLAGS: next_rdata = pif.flag;
            pci_pkg::ADDR_IRQ_CAPTURE: next_rdata = irq_capture;
            default: next_rdata = pci_pkg::ZERO_BYTE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= pci_pkg::ZERO_BYTE;
        end else if (ce && reg_rd) begin
            reg_rdata <= next_rdata;
        end
    end

    // A condition in the clearing cycle starts a fresh interrupt at once
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            pending <= 1'b0;
        end else if (ce) begin
            if (read_clear) begin
                pending <= any_cond;
            end else if (any_cond) begin
                pending <= 1'b1;
            end
        end
    end

    // Capture only on the event that opens an interrupt
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_capture <= pci_pkg::RST_CAPTURE;
        end else if (ce && any_cond && (!pending || read_clear)) begin
            irq_capture <= port_sync;
        end
    end

    // Interrupt pad: open-drain ignores polarity and only sinks when active
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_pin_o <= 1'b1;
            irq_pin_oe <= 1'b1;
        end else if (ce) begin
            if (open_drain) begin
                irq_pin_o <= 1'b0;
                irq_pin_oe <= pending;
            end else begin
                irq_pin_o <= pending ? active_high : ~active_high;
                irq_pin_oe <= 1'b1;
            end
        end
    end

    // Pad and engine controls, registered
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            pullup_enable <= pci_pkg::ZERO_BYTE;
            addr_autoinc_disable <= 1'b0;
            data_slew_disable <= 1'b0;
            hw_address_enable <= 1'b1;
        end else if (ce) begin
            pullup_enable <= pullup_enable_reg & pin_is_input;
            addr_autoinc_disable <= expander_configuration[pci_pkg::CFG_AUTOINC_DIS_BIT];
            data_slew_disable <= expander_configuration[pci_pkg::CFG_SLEW_DIS_BIT];
            // The I2C variant always compares its address pins
            hw_address_enable <= SPI_VARIANT
                ? expander_configuration[pci_pkg::CFG_HW_ADDR_EN_BIT] : 1'b1;
        end
    end

    // Helper views for the checks below
    logic [7:0] live_bits;
    logic [7:0] def_hits;
    assign live_bits = pin_change_irq_enable & pin_is_input;
    assign def_hits = live_bits & compare_mode_select & (port_sync ^ compare_default_value);
    logic autoinc_sel;
    logic slew_sel;
    logic hw_addr_sel;
    assign autoinc_sel = expander_configuration[pci_pkg::CFG_AUTOINC_DIS_BIT];
    assign slew_sel = expander_configuration[pci_pkg::CFG_SLEW_DIS_BIT];
    assign hw_addr_sel = expander_configuration[pci_pkg::CFG_HW_ADDR_EN_BIT];

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!reset_n);

    // Qualification, compare and flag behaviour
    a_enable_gate: assert property (ce |=> (pif.flag & ~$past(live_bits)) == 8'h00)
        else $error("flag set on a disabled pin");
    a_output_quiet: assert property (ce |=> (pif.cond & ~pin_is_input) == 8'h00)
        else $error("output pin produced a condition");
    a_default_hit: assert property (
        ce && def_hits != 8'h00
        |=> (pif.flag & $past(def_hits)) == $past(def_hits) && pending)
        else $error("default compare miss not flagged");
    // The pin must hold still for a cycle, or a genuine new change fires again
    a_prev_hit: assert property (
        ce && (pif.cond & live_bits & ~compare_mode_select) != 8'h00
        ##1 $stable(port_sync) |-> (pif.cond & ~compare_mode_select) == 8'h00)
        else $error("previous reference not updated");
    a_pending_set: assert property (ce && any_cond |=> pending)
        else $error("condition did not raise the interrupt");
    a_flag_pending: assert property (pif.flag != 8'h00 |-> pending)
        else $error("flag set without a pending interrupt");
    a_ce_freeze: assert property (
        !ce |=> $stable(pending) && $stable(irq_capture) && $stable(pif.flag))
        else $error("state moved while clock enable low");

    // Register port
    a_cfg_reserved: assert property (
        (expander_configuration & pci_pkg::CFG_RESERVED_MASK) == 8'h00)
        else $error("reserved config bit set");
    a_cfg_write: assert property (
        ce && reg_wr && reg_addr == pci_pkg::ADDR_CONFIG
        |=> expander_configuration == ($past(reg_wdata) & pci_pkg::CFG_WRITABLE_MASK))
        else $error("config write not masked");
    a_enable_write: assert property (
        ce && reg_wr && reg_addr == pci_pkg::ADDR_IRQ_ENABLE
        |=> pin_change_irq_enable == $past(reg_wdata))
        else $error("enable write lost");
    a_mode_write: assert property (
        ce && reg_wr && reg_addr == pci_pkg::ADDR_CMP_MODE
        |=> compare_mode_select == $past(reg_wdata))
        else $error("compare mode write lost");
    a_flag_ro: assert property (
        ce && reg_wr && reg_addr == pci_pkg::ADDR_IRQ_FLAGS
        && !any_cond && !read_clear |=> $stable(pif.flag))
        else $error("flag register changed by write");
    a_read_config: assert property (
        ce && reg_rd && reg_addr == pci_pkg::ADDR_CONFIG
        |=> reg_rdata == $past(expander_configuration))
        else $error("config read wrong");
    a_read_flags: assert property (
        ce && reg_rd && reg_addr == pci_pkg::ADDR_IRQ_FLAGS |=> reg_rdata == $past(pif.flag))
        else $error("flag read wrong");
    a_read_capture: assert property (
        ce && reg_rd && reg_addr == pci_pkg::ADDR_IRQ_CAPTURE
        |=> reg_rdata == $past(irq_capture))
        else $error("capture read wrong");

    // Capture and clearing
    a_capture_load: assert property (
        ce && any_cond && !pending |=> irq_capture == $past(port_sync))
        else $error("capture missed the first event");
    a_capture_hold: assert property (ce && pending && !read_clear |=> $stable(irq_capture))
        else $error("capture changed while pending");
    a_read_clears: assert property (
        read_clear && !any_cond |=> !pending && pif.flag == 8'h00)
        else $error("read did not clear interrupt");
    a_write_keeps: assert property (ce && pending && reg_wr && !reg_rd |=> pending)
        else $error("write cleared interrupt");

    // Pads and engine controls
    a_pullup_gate: assert property (
        ce |=> pullup_enable == ($past(pullup_enable_reg) & $past(pin_is_input)))
        else $error("pull-up enabled on output");
    a_cfg_outputs: assert property (
        ce |=> addr_autoinc_disable == $past(autoinc_sel)
        && data_slew_disable == $past(slew_sel))
        else $error("engine control does not follow config");
    a_hw_addr: assert property (
        ce |=> hw_address_enable == (SPI_VARIANT ? $past(hw_addr_sel) : 1'b1))
        else $error("address pin enable wrong");
    a_pad_idle: assert property (
        ce && !pending |=> ($past(open_drain) ? !irq_pin_oe
        : (irq_pin_oe && irq_pin_o == !$past(active_high))))
        else $error("idle interrupt pad not inactive");
    a_pad_active: assert property (
        ce && pending |=> ($past(open_drain) ? (irq_pin_oe && !irq_pin_o)
        : (irq_pin_oe && irq_pin_o == $past(active_high))))
        else $error("active interrupt pad wrong");
    a_pad_driven: assert property (ce && !open_drain |=> irq_pin_oe)
        else $error("push-pull pad not driven");

    c_default_irq: cover property (ce && def_hits != 8'h00 && !pending);
    c_prev_irq: cover property (ce && (pif.cond & ~compare_mode_select) != 8'h00);
    c_second_pin: cover property (ce && pending && any_cond && !read_clear);
    c_read_clear: cover property (read_clear && pending);
    c_open_drain_irq: cover property (ce && open_drain && pending);

endmodule : pci_ctrl

// File: core/pci_pin_detect.sv
// Change detector and interrupt flag for one port bit.
// Assumes the controller drives the bundle fields on sys_clk.
`timescale 1ns/1ns
module pci_pin_detect #(
    parameter int unsigned IDX = 0
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Bundle to the controller
    pci_pin_if.pin p
);

    logic ref_level;
    logic flag;
    logic live;
    logic cond;

    // Output pins and disabled pins never qualify
    assign live = p.enable[IDX] & p.is_input[IDX];
    // Mode 1: against default bit; mode 0: against last recorded level
    assign cond = live & (p.mode[IDX] ? (p.level[IDX] ^ p.default_val[IDX])
                                      : (p.level[IDX] ^ ref_level));
    assign p.cond[IDX] = cond;
    assign p.flag[IDX] = flag;

    // Reference follows the pin whenever it is not armed in previous mode,
    // so arming never fires on a stale level
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            ref_level <= 1'b0;
        end else if (p.ce) begin
            if (cond || !(live && !p.mode[IDX])) begin
                ref_level <= p.level[IDX];
            end
        end
    end

    // New condition wins over the read-clear in the same cycle
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            flag <= 1'b0;
        end else if (p.ce) begin
            flag <= cond | (flag & live & ~p.clear);
        end
    end

endmodule : pci_pin_detect

// File: core/pci_sync.sv
// Three-stage input synchroniser with agreement filter.
// Assumes inputs asynchronous to sys_clk; output moves only when stages two and three agree.
`timescale 1ns/1ns
module pci_sync #(
    parameter int unsigned W = 8
) (
    // Clock, reset, enable
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic ce,
    // Data
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);

    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
    logic [W-1:0] stage3;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
        end else if (ce) begin
            stage1 <= async_in;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    // Per bit, a level only counts once two stages agree, masking a late settle
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            sync_out <= '0;
        end else if (ce) begin
            for (int i = 0; i < W; i++) begin
                if (stage2[i] == stage3[i]) begin
                    sync_out[i] <= stage3[i];
                end
            end
        end
    end

endmodule : pci_sync

// File: inc/pci_pin_if.sv
// Bundle between the controller and its per-pin change detectors.
// Assumes one detector instance per port bit; each drives only its own bit.
`timescale 1ns/1ns
interface pci_pin_if;
    logic ce;
    logic clear;
    logic [7:0] enable;
    logic [7:0] is_input;
    logic [7:0] mode;
    logic [7:0] default_val;
    logic [7:0] level;
    wire logic [7:0] cond;
    wire logic [7:0] flag;

    modport ctrl (
        output ce, clear, enable, is_input, mode, default_val, level,
        input cond, flag
    );
    modport pin (
        input ce, clear, enable, is_input, mode, default_val, level,
        output cond, flag
    );
endinterface : pci_pin_if

// File: inc/pci_pkg.sv
// Constants for the pin-change interrupt and configuration block.
// Assumes an 8-bit register port driven by the serial protocol engine.
package pci_pkg;

    localparam int unsigned PORT_W = 8;

    // Register offsets on the internal register port
    localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h02;
    localparam logic [7:0] ADDR_CMP_DEFAULT = 8'h03;
    localparam logic [7:0] ADDR_CMP_MODE = 8'h04;
    localparam logic [7:0] ADDR_CONFIG = 8'h05;
    localparam logic [7:0] ADDR_PULLUP = 8'h06;
    localparam logic [7:0] ADDR_IRQ_FLAGS = 8'h07;
    localparam logic [7:0] ADDR_IRQ_CAPTURE = 8'h08;
    localparam logic [7:0] ADDR_PORT_VALUE = 8'h09;

    // Reset values
    localparam logic [7:0] RST_IRQ_ENABLE = 8'h00;
    localparam logic [7:0] RST_CMP_DEFAULT = 8'h00;
    localparam logic [7:0] RST_CMP_MODE = 8'h00;
    localparam logic [7:0] RST_CONFIG = 8'h00;
    localparam logic [7:0] RST_PULLUP = 8'h00;
    localparam logic [7:0] RST_FLAGS = 8'h00;
    localparam logic [7:0] RST_CAPTURE = 8'h00;
    localparam logic [7:0] ZERO_BYTE = 8'h00;

    // Configuration register fields
    localparam int unsigned CFG_AUTOINC_DIS_BIT = 5;
    localparam int unsigned CFG_SLEW_DIS_BIT = 4;
    localparam int unsigned CFG_HW_ADDR_EN_BIT = 3;
    localparam int unsigned CFG_OPEN_DRAIN_BIT = 2;
    localparam int unsigned CFG_ACTIVE_HIGH_BIT = 1;
    localparam logic [7:0] CFG_WRITABLE_MASK = 8'h3E;
    localparam logic [7:0] CFG_RESERVED_MASK = 8'hC1;

endpackage : pci_pkg

// File: testbench/pci_host_model.sv
// Host side of the register port: single-byte write and read strobes.
// Assumes the bench calls its tasks; every signal moves on a falling edge.
`timescale 1ns/1ns
module pci_host_model (
    // Clock
    input wire logic sys_clk,
    // Register port
    output logic [7:0] reg_addr,
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata
);
    initial begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 8'h00;
    end

    // Idle address and data are inverted so a stale byte cannot pass for a live one
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge sys_clk);
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask : wr

    // Read data is registered, so it is taken one cycle after the strobe edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge sys_clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge sys_clk);
        reg_rd = 1'b0;
        reg_addr = ~a;
        d = reg_rdata;
    endtask : rd
endmodule : pci_host_model

// File: testbench/port_change_interrupt_config_tb_top.sv
// Self-checking bench for the pin-change interrupt and configuration block.
// Assumes pci_ctrl and pci_host_model are compiled first; inputs move on falling edges.
`timescale 1ns/1ns
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin n_errors++; \
    $display("[FAIL] %0t got %h exp %h", $time, (a), (e)); end end
module port_change_interrupt_config_tb_top;
    logic sys_clk;
    logic reset_n;
    logic ce;
    logic [7:0] reg_addr;
    logic reg_wr;
    logic reg_rd;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    logic [7:0] pin_level;
    logic [7:0] pin_is_input;
    logic [7:0] pullup_enable;
    logic [7:0] irq_capture;
    logic addr_autoinc_disable;
    logic data_slew_disable;
    logic hw_address_enable;
    logic i2c_hw_address_enable;
    logic irq_pin_o;
    logic irq_pin_oe;
    logic [7:0] rdv;
    int n_errors = 0;
    int checks_done = 0;

    pci_host_model u_host (.sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

    pci_ctrl #(.SPI_VARIANT(1'b1)) u_dut (.sys_clk(sys_clk), .reset_n(reset_n), .ce(ce),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .pin_level(pin_level), .pin_is_input(pin_is_input),
        .pullup_enable(pullup_enable), .irq_capture(irq_capture),
        .addr_autoinc_disable(addr_autoinc_disable), .data_slew_disable(data_slew_disable),
        .hw_address_enable(hw_address_enable), .irq_pin_o(irq_pin_o),
        .irq_pin_oe(irq_pin_oe));

    // Second variant only shows that the address pins stay enabled
    pci_ctrl #(.SPI_VARIANT(1'b0)) u_dut_i2c (.sys_clk(sys_clk), .reset_n(reset_n),
        .ce(ce), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(), .pin_level(pin_level),
        .pin_is_input(pin_is_input), .pullup_enable(), .irq_capture(),
        .addr_autoinc_disable(), .data_slew_disable(),
        .hw_address_enable(i2c_hw_address_enable), .irq_pin_o(), .irq_pin_oe());

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic tick(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : tick

    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        u_host.rd(a, d);
        `CHK(d, e)
    endtask : rchk

    task automatic conclude();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : conclude

    initial begin
        repeat (3000) @(posedge sys_clk);
        n_errors++;
        conclude();
    end

    initial begin
        reset_n = 1'b0;
        ce = 1'b1;
        pin_level = 8'h00;
        pin_is_input = 8'hFF;
        tick(4);
        `CHK(irq_pin_o, 1'b1);
        `CHK(irq_pin_oe, 1'b1);
        reset_n = 1'b1;
        for (int a = 2; a < 9; a++) begin
            rchk(8'(a), 8'h00);
        end
        // Every configuration bit set, reserved ones included
        u_host.wr(8'h05, 8'hFF);
        rchk(8'h05, 8'h3E);
        `CHK(addr_autoinc_disable, 1'b1);
        `CHK(data_slew_disable, 1'b1);
        `CHK(hw_address_enable, 1'b1);
        `CHK(irq_pin_oe, 1'b0);
        u_host.wr(8'h05, 8'h00);
        rchk(8'h05, 8'h00);
        `CHK(addr_autoinc_disable, 1'b0);
        `CHK(data_slew_disable, 1'b0);
        `CHK(hw_address_enable, 1'b0);
        `CHK(i2c_hw_address_enable, 1'b1);
        `CHK(irq_pin_o, 1'b1);
        `CHK(irq_pin_oe, 1'b1);
        u_host.wr(8'h05, 8'h02);
        tick(2);
        `CHK(irq_pin_o, 1'b0);
        u_host.wr(8'h07, 8'hFF);
        rchk(8'h07, 8'h00);
        // Pull-ups only on input pins
        pin_is_input = 8'h3C;
        u_host.wr(8'h06, 8'hF0);
        tick(2);
        `CHK(pullup_enable, 8'h30);
        rchk(8'h06, 8'hF0);
        pin_is_input = 8'hFF;
        // Compare against the default value, pin 0 armed, pin 1 not
        u_host.wr(8'h03, 8'h00);
        u_host.wr(8'h04, 8'h03);
        u_host.wr(8'h02, 8'h01);
        pin_level = 8'h03;
        tick(8);
        `CHK(irq_pin_o, 1'b1);
        rchk(8'h07, 8'h01);
        `CHK(irq_capture, 8'h03);
        rchk(8'h08, 8'h03);
        pin_level = 8'h00;
        tick(8);
        // Flag now held with no live condition, so a write could only clear it wrongly
        u_host.wr(8'h07, 8'h00);
        u_host.wr(8'h08, 8'h00);
        u_host.wr(8'h09, 8'h00);
        tick(3);
        `CHK(irq_pin_o, 1'b1);
        rchk(8'h07, 8'h01);
        u_host.rd(8'h09, rdv);
        tick(3);
        `CHK(irq_pin_o, 1'b0);
        rchk(8'h07, 8'h00);
        // Previous-value compare, open drain, pin 3 an output
        u_host.wr(8'h02, 8'h00);
        u_host.wr(8'h04, 8'h00);
        u_host.wr(8'h05, 8'h06);
        pin_is_input = 8'hF7;
        u_host.wr(8'h02, 8'h0F);
        tick(2);
        `CHK(irq_pin_oe, 1'b0);
        pin_level = 8'h01;
        tick(8);
        `CHK(irq_pin_oe, 1'b1);
        `CHK(irq_pin_o, 1'b0);
        pin_level = 8'h0D;
        tick(8);
        rchk(8'h07, 8'h05);
        `CHK(irq_capture, 8'h01);
        rchk(8'h08, 8'h01);
        tick(8);
        `CHK(irq_pin_oe, 1'b0);
        rchk(8'h07, 8'h00);
        conclude();
    end
endmodule : port_change_interrupt_config_tb_top
